// ==== t8w_timer.sv ====
`timescale 1ns/1ps
`include "t8w_cfg.svh"

// Summary of operation
// RL1: Only mode field changes counting sequence.
// RL2: Normal mode counts up, wraps FF to 00.
// RL3: Normal mode sets overflow when count becomes zero.
// RL4: Overflow flag clears when its interrupt is serviced.
// RL5: Clear-on-match mode clears counter on compare match.
// RL6: Clear-on-match compare writes apply immediately.
// RL7: Clear-on-match setting 1 toggles output on match.
// RL8: Output reaches pin only when direction is output.
// RL9: Clear-on-match sets overflow on MAX to zero.
// RL10: Fast PWM counts bottom to MAX, then clears.
// RL11: Fast PWM settings 2/3 clear/set on match.
// RL12: Fast PWM sets overflow each time at MAX.
// RL13: Fast PWM period is 256 ticks.
// RL14: Fast PWM extremes: spike at BOTTOM, constant at MAX.
// RL15: Phase-correct counts up then down, MAX once.
// RL16: Phase-correct resolution fixed at eight bits.
// RL17: Phase-correct output action depends on direction.
// RL18: Phase-correct sets overflow at BOTTOM.
// RL19: Phase-correct period is 510 ticks.
// RL20: Phase-correct extremes give constant output levels.
// RL21: At MAX output takes up-count match result; the code keeps the down-count result when the incoming compare is MAX.
// RL22: Compare flag set one tick after equality.
// RL23: PWM compare writes buffered, loaded at TOP/BOTTOM.
// RL24: Count write blocks match on next tick.
// RL25: Reserved PWM setting leaves output and pin alone.
module t8w_timer (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        timer_tick,
    input  wire logic        overflow_serviced,
    input  wire logic        compare_serviced,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             waveform_output,
    output logic             waveform_output_oe,
    output logic             overflow_flag,
    output logic             compare_match_flag
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    t8w_pkg::t8w_ctrl_s  ctrl;
    t8w_pkg::t8w_flags_s flags;
    logic [7:0]          count_value;
    logic [7:0]          compare_value;
    logic [7:0]          compare_active;
    logic                count_down;
    logic                match_block;
    logic                wave_state;
    logic                pin_enable;

    logic [7:0]          next_count;
    logic                next_wave;
    logic [31:0]         next_rdata;

    logic                apb_write;
    logic                apb_setup;
    logic                addr_ok;
    logic                ctrl_wr;
    logic                count_wr;
    logic                compare_wr;
    logic                flags_wr;
    logic                force_wr;
    logic                step;
    logic                is_pwm;
    logic                at_max;
    logic                at_bottom;
    logic                match;
    logic                load_buffer;
    logic                ovf_set;
    logic                cmp_set;
    logic                ovf_clr;
    logic                cmp_clr;
    logic                connected;
    logic                up_result;
    logic                match_up;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Zero wait states: read data is captured in the setup cycle so that
    // prdata comes from a flop and still stands in the access cycle.
    assign pready    = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;

    always_comb begin
        unique case (paddr)
            `T8W_ADDR_CTRL,
            `T8W_ADDR_COUNT,
            `T8W_ADDR_COMPARE,
            `T8W_ADDR_FLAGS,
            `T8W_ADDR_STATUS: addr_ok = 1'b1;
            default:          addr_ok = 1'b0;
        endcase
    end

    assign pslverr    = psel && penable && !addr_ok;
    assign ctrl_wr    = apb_write && (paddr == `T8W_ADDR_CTRL);
    assign count_wr   = apb_write && (paddr == `T8W_ADDR_COUNT);
    assign compare_wr = apb_write && (paddr == `T8W_ADDR_COMPARE);
    assign flags_wr   = apb_write && (paddr == `T8W_ADDR_FLAGS);
    assign force_wr   = ctrl_wr && pwdata[`T8W_CTRL_FORCE_BIT];

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            `T8W_ADDR_CTRL: begin
                next_rdata[`T8W_CTRL_MODE_LSB +: 2] = ctrl.waveform_mode_sel;
                next_rdata[`T8W_CTRL_COS_LSB +: 2]  = ctrl.compare_output_sel;
                next_rdata[`T8W_CTRL_DDR_BIT]       = ctrl.pin_dir_out;
            end
            `T8W_ADDR_COUNT: begin
                next_rdata[7:0] = count_value;
            end
            `T8W_ADDR_COMPARE: begin
                next_rdata[7:0] = compare_value;
            end
            `T8W_ADDR_FLAGS: begin
                next_rdata[`T8W_FLAG_OVF_BIT] = flags.overflow_flag;
                next_rdata[`T8W_FLAG_CMP_BIT] = flags.compare_match_flag;
            end
            `T8W_ADDR_STATUS: begin
                next_rdata[`T8W_STAT_WAVE_BIT]     = wave_state;
                next_rdata[`T8W_STAT_DOWN_BIT]     = count_down;
                next_rdata[`T8W_STAT_BLOCK_BIT]    = match_block;
                next_rdata[`T8W_STAT_ACT_LSB +: 8] = compare_active;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // The force bit is a strobe and is not stored, so it always reads zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl.waveform_mode_sel  <= t8w_pkg::t8w_mode_e'(`T8W_RST_MODE);
            ctrl.compare_output_sel <= `T8W_RST_COS;
            ctrl.pin_dir_out        <= 1'b0;
        end else if (ctrl_wr) begin
            ctrl.waveform_mode_sel  <=
                t8w_pkg::t8w_mode_e'(pwdata[`T8W_CTRL_MODE_LSB +: 2]);
            ctrl.compare_output_sel <= pwdata[`T8W_CTRL_COS_LSB +: 2];
            ctrl.pin_dir_out        <= pwdata[`T8W_CTRL_DDR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Counter unit
    // ------------------------------------------------------------------
    // A software write to the count overrides any tick in the same cycle,
    // so every tick-driven event below is qualified with !count_wr.
    assign step      = timer_tick && !count_wr;
    assign is_pwm    = (ctrl.waveform_mode_sel == t8w_pkg::T8W_PHASE_CORRECT) ||
                       (ctrl.waveform_mode_sel == t8w_pkg::T8W_FAST_PWM);
    assign at_max    = (count_value == `T8W_COUNT_MAX);
    assign at_bottom = (count_value == `T8W_COUNT_BOTTOM);
    assign match     = (count_value == compare_active) && !match_block; // [RL24]

    // Only the mode field steers the sequence; the output setting is unused here. [RL1]
    always_comb begin
        next_count = 8'(count_value + 8'h01);
        unique case (ctrl.waveform_mode_sel)
            t8w_pkg::T8W_NORMAL: begin
                next_count = 8'(count_value + 8'h01); // [RL2]
            end
            t8w_pkg::T8W_CLEAR_ON_MATCH: begin
                // Unbuffered top: a top below the count is passed by and the
                // counter wraps through FF before the next match. [RL6]
                if (match) begin
                    next_count = `T8W_COUNT_BOTTOM; // [RL5]
                end
            end
            t8w_pkg::T8W_FAST_PWM: begin
                // Eight-bit wrap gives MAX then BOTTOM, 256 ticks a period. [RL10] [RL13]
                next_count = 8'(count_value + 8'h01);
            end
            t8w_pkg::T8W_PHASE_CORRECT: begin
                // Fixed eight-bit turn points: 255 up plus 255 down. [RL15] [RL16] [RL19]
                if (count_down) begin
                    next_count = at_bottom ? 8'(count_value + 8'h01)
                                           : 8'(count_value - 8'h01);
                end else begin
                    next_count = at_max ? 8'(count_value - 8'h01)
                                        : 8'(count_value + 8'h01);
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_value <= `T8W_RST_COUNT;
        end else if (count_wr) begin
            count_value <= pwdata[7:0];
        end else if (timer_tick) begin
            count_value <= next_count;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_down <= 1'b0;
        end else if (ctrl.waveform_mode_sel != t8w_pkg::T8W_PHASE_CORRECT) begin
            count_down <= 1'b0;
        end else if (step) begin
            if (!count_down && at_max) begin
                count_down <= 1'b1; // [RL15]
            end else if (count_down && at_bottom) begin
                count_down <= 1'b0;
            end
        end
    end

    // The block survives until a tick has passed, even with the timer stopped.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            match_block <= 1'b0;
        end else if (count_wr) begin
            match_block <= 1'b1; // [RL24]
        end else if (timer_tick) begin
            match_block <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Compare value and its buffer
    // ------------------------------------------------------------------
    // Both PWM modes load at the MAX tick: that is TOP for the dual slope
    // and the step into BOTTOM for the single slope.
    assign load_buffer = step && is_pwm && at_max; // [RL23]

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            compare_value <= `T8W_RST_COMPARE;
        end else if (compare_wr) begin
            compare_value <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            compare_active <= `T8W_RST_COMPARE;
        end else if (compare_wr && !is_pwm) begin
            compare_active <= pwdata[7:0]; // [RL6] [RL23]
        end else if (load_buffer) begin
            compare_active <= compare_value; // [RL23]
        end
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    always_comb begin
        unique case (ctrl.waveform_mode_sel)
            t8w_pkg::T8W_PHASE_CORRECT: ovf_set = step && count_down && at_bottom; // [RL18]
            t8w_pkg::T8W_FAST_PWM:      ovf_set = step && at_max; // [RL12]
            t8w_pkg::T8W_CLEAR_ON_MATCH: ovf_set = step && at_max; // [RL9]
            t8w_pkg::T8W_NORMAL:        ovf_set = step && at_max; // [RL3]
        endcase
    end

    assign cmp_set = step && match; // [RL22]
    assign ovf_clr = overflow_serviced ||
                     (flags_wr && pwdata[`T8W_FLAG_OVF_BIT]); // [RL4]
    assign cmp_clr = compare_serviced ||
                     (flags_wr && pwdata[`T8W_FLAG_CMP_BIT]);

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags.overflow_flag      <= ovf_set || (flags.overflow_flag && !ovf_clr); // [RL3]
            flags.compare_match_flag <= cmp_set ||
                                        (flags.compare_match_flag && !cmp_clr);
        end
    end

    assign overflow_flag      = flags.overflow_flag;
    assign compare_match_flag = flags.compare_match_flag;

    // ------------------------------------------------------------------
    // Waveform generator
    // ------------------------------------------------------------------
    // Settings 2 and 3 in PWM: bit 0 is the level a rising match leaves.
    assign up_result = ctrl.compare_output_sel[0];
    // The BOTTOM tick turns the slope upward, so its match counts as rising.
    assign match_up  = !count_down || at_bottom;

    always_comb begin
        next_wave = wave_state;
        if (!is_pwm) begin
            // Forced matches act on the output only, never on flags or count.
            if (force_wr || (step && match)) begin
                unique case (ctrl.compare_output_sel)
                    2'h0: next_wave = wave_state;
                    2'h1: next_wave = !wave_state; // [RL7]
                    2'h2: next_wave = 1'b0;
                    2'h3: next_wave = 1'b1;
                endcase
            end
        end else if (ctrl.compare_output_sel[1] && step) begin
            // Setting 1 is reserved in PWM and falls through untouched. [RL25]
            if (ctrl.waveform_mode_sel == t8w_pkg::T8W_FAST_PWM) begin
                // BOTTOM action beats a match at MAX, so a compare of MAX
                // holds a constant level and zero gives a one-tick spike.
                if (at_max) begin
                    next_wave = !up_result; // [RL11] [RL14]
                end else if (match) begin
                    next_wave = up_result; // [RL11] [RL14]
                end
            end else begin
                // At TOP the rising result is forced, unless the incoming
                // compare is MAX, which keeps the falling result. [RL21]
                if (at_max) begin
                    next_wave = (compare_value == `T8W_COUNT_MAX) ? !up_result
                                                                  : up_result; // [RL20]
                end else if (match) begin
                    next_wave = match_up ? up_result : !up_result; // [RL17] [RL20]
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wave_state <= 1'b0;
        end else begin
            wave_state <= next_wave;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    assign connected = (ctrl.compare_output_sel != 2'h0) &&
                       !(is_pwm && (ctrl.compare_output_sel == 2'h1)); // [RL25]

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_enable <= 1'b0;
        end else begin
            pin_enable <= connected && ctrl.pin_dir_out; // [RL8]
        end
    end

    assign waveform_output    = wave_state;
    assign waveform_output_oe = pin_enable;

endmodule : t8w_timer

// ==== t8w_cfg.svh ====
`ifndef T8W_CFG_SVH
`define T8W_CFG_SVH

// Register byte offsets on the APB slave.
`define T8W_ADDR_CTRL       8'h00
`define T8W_ADDR_COUNT      8'h04
`define T8W_ADDR_COMPARE    8'h08
`define T8W_ADDR_FLAGS      8'h0C
`define T8W_ADDR_STATUS     8'h10

// Control register field positions.
`define T8W_CTRL_MODE_LSB   0
`define T8W_CTRL_COS_LSB    2
`define T8W_CTRL_FORCE_BIT  4
`define T8W_CTRL_DDR_BIT    5

// Flag register and status register field positions.
`define T8W_FLAG_OVF_BIT    0
`define T8W_FLAG_CMP_BIT    1
`define T8W_STAT_WAVE_BIT   0
`define T8W_STAT_DOWN_BIT   1
`define T8W_STAT_BLOCK_BIT  2
`define T8W_STAT_ACT_LSB    8

// Count limits and reset values.
`define T8W_COUNT_MAX       8'hFF
`define T8W_COUNT_BOTTOM    8'h00
`define T8W_RST_COUNT       8'h00
`define T8W_RST_COMPARE     8'h00
`define T8W_RST_MODE        2'h0
`define T8W_RST_COS         2'h0

`endif

// ==== t8w_pkg.sv ====
package t8w_pkg;

    // Encoding order matches the two-bit mode field: 0, 1, 2, 3.
    typedef enum logic [1:0] {
        T8W_NORMAL,
        T8W_PHASE_CORRECT,
        T8W_CLEAR_ON_MATCH,
        T8W_FAST_PWM
    } t8w_mode_e;

    typedef struct packed {
        logic       pin_dir_out;
        logic [1:0] compare_output_sel;
        t8w_mode_e  waveform_mode_sel;
    } t8w_ctrl_s;

    typedef struct packed {
        logic compare_match_flag;
        logic overflow_flag;
    } t8w_flags_s;

endpackage : t8w_pkg

// ==== t8w_pin_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Port pin with a weak pull-up
// ------------------------------------------------------------------
module t8w_pin_model (
    input  wire logic drive,
    input  wire logic drive_en,
    output logic      pin_level
);
    // An undriven pin settles at the pull-up, so a stale wave value never shows.
    assign pin_level = drive_en ? drive : 1'b1;
endmodule : t8w_pin_model

// ==== t8w_checker.sv ====
`timescale 1ns/1ps
`include "t8w_cfg.svh"

// ------------------------------------------------------------------
// Port-level checker for the timer
// ------------------------------------------------------------------
module t8w_checker (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        timer_tick,
    input  wire logic        overflow_serviced,
    input  wire logic        compare_serviced,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        waveform_output,
    input  wire logic        waveform_output_oe,
    input  wire logic        overflow_flag,
    input  wire logic        compare_match_flag
);
    logic       wr_acc;
    logic       clr_ovf;
    logic       wr_count;
    logic [5:0] ctrl_sh;
    logic       oe_exp;

    assign wr_acc   = psel & penable & pwrite & pready;
    assign clr_ovf  = wr_acc & (paddr == `T8W_ADDR_FLAGS) & pwdata[0];
    assign wr_count = wr_acc & (paddr == `T8W_ADDR_COUNT);

    // Shadow of the control word, kept from the bus alone.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_sh <= 6'h00;
        end else if (wr_acc && paddr == `T8W_ADDR_CTRL) begin
            ctrl_sh <= pwdata[5:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oe_exp <= 1'b0;
        end else begin
            oe_exp <= ctrl_sh[5] & (ctrl_sh[3:2] != 2'h0) & !(ctrl_sh[0] & ctrl_sh[3:2] == 2'h1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_ovf_hold;
        overflow_flag && !overflow_serviced && !clr_ovf |=> overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");

    property p_ovf_service;
        overflow_serviced && !timer_tick |=> !overflow_flag;
    endproperty
    a_ovf_service: assert property (p_ovf_service) else $error("overflow not cleared");

    property p_ovf_tick;
        !overflow_flag && !timer_tick |=> !overflow_flag;
    endproperty
    a_ovf_tick: assert property (p_ovf_tick) else $error("overflow set without tick");

    property p_cmp_tick;
        !compare_match_flag && !timer_tick |=> !compare_match_flag;
    endproperty
    a_cmp_tick: assert property (p_cmp_tick) else $error("match flag set without tick");

    property p_pin_en;
        waveform_output_oe == oe_exp;
    endproperty
    a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");

    property p_reserved;
        ctrl_sh[0] && ctrl_sh[3:2] == 2'h1 && !wr_acc |=> $stable(waveform_output);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved setting moved wave");

    property p_wave_tick;
        !timer_tick && !wr_acc |=> $stable(waveform_output);
    endproperty
    a_wave_tick: assert property (p_wave_tick) else $error("wave moved without tick");

    property p_match_block;
        wr_count && !compare_match_flag ##1 timer_tick && !wr_acc |=> !compare_match_flag;
    endproperty
    a_match_block: assert property (p_match_block) else $error("match not blocked");
endmodule : t8w_checker

bind t8w_timer t8w_checker t8w_checker_i (
    .clock              (clock),
    .rst_n              (rst_n),
    .timer_tick         (timer_tick),
    .overflow_serviced  (overflow_serviced),
    .compare_serviced   (compare_serviced),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .waveform_output    (waveform_output),
    .waveform_output_oe (waveform_output_oe),
    .overflow_flag      (overflow_flag),
    .compare_match_flag (compare_match_flag)
);

// ==== t8w_tb.sv ====
`timescale 1ns/1ps
`include "t8w_cfg.svh"

module tb;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        timer_tick = 1'b0;
    logic        overflow_serviced = 1'b0;
    logic        compare_serviced = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        waveform_output;
    logic        waveform_output_oe;
    logic        overflow_flag;
    logic        compare_match_flag;
    logic        pin_level;
    int          errors = 0;
    int          comparisons = 0;

    t8w_timer t8w_timer_i (.clock(clock), .rst_n(rst_n), .timer_tick(timer_tick),
        .overflow_serviced(overflow_serviced), .compare_serviced(compare_serviced),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .waveform_output(waveform_output), .waveform_output_oe(waveform_output_oe),
        .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));

    t8w_pin_model t8w_pin_model_i (.drive(waveform_output), .drive_en(waveform_output_oe),
        .pin_level(pin_level));

    initial begin
        forever #20 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, err_exp});
    endtask : rd_chk

    // Leaves the bench at a falling edge so that outputs have settled.
    task automatic ticks(input int n);
        @(posedge clock);
        timer_tick <= 1'b1;
        repeat (n) @(posedge clock);
        timer_tick <= 1'b0;
        @(negedge clock);
    endtask : ticks

    task automatic svc();
        @(posedge clock);
        overflow_serviced <= 1'b1;
        compare_serviced  <= 1'b1;
        @(posedge clock);
        overflow_serviced <= 1'b0;
        compare_serviced  <= 1'b0;
        @(negedge clock);
    endtask : svc

    // A window of one full period gives the same high count whatever its phase.
    task automatic run_pwm(input logic [1:0] mode, input logic [1:0] cos, input logic [7:0] cmp,
                           input int period, input int high_exp);
        int k;
        int high;
        int first;
        wr(`T8W_ADDR_CTRL, 32'h0);
        wr(`T8W_ADDR_COMPARE, {24'h0, cmp});
        wr(`T8W_ADDR_CTRL, {26'h2, cos, mode});
        wr(`T8W_ADDR_COUNT, 32'h0);
        wr(`T8W_ADDR_FLAGS, 32'h3);
        @(posedge clock);
        timer_tick <= 1'b1;
        k = 0;
        while (overflow_flag !== 1'b1 && k < 1200) begin
            @(posedge clock);
            k++;
        end
        overflow_serviced <= 1'b1;
        high = 0;
        first = 0;
        for (k = 1; k <= period; k++) begin
            @(posedge clock);
            overflow_serviced <= 1'b0;
            high += int'(pin_level);
            if (k > 1 && overflow_flag === 1'b1 && first == 0) first = k;
        end
        timer_tick <= 1'b0;
        check(first, period);
        check(high, high_exp);
        check({31'h0, waveform_output_oe}, {31'h0, cos != 2'h1});
    endtask : run_pwm

    task automatic finish_test();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a <= 'h14; a += 4) rd_chk(8'(a), 32'h0, a == 'h14);
        wr(`T8W_ADDR_CTRL, 32'h0000_0008);
        wr(`T8W_ADDR_FLAGS, 32'h3);
        wr(`T8W_ADDR_COUNT, 32'hFE);
        ticks(1);
        check(overflow_flag, 32'h0);
        rd_chk(`T8W_ADDR_COUNT, 32'hFF, 1'b0);
        ticks(1);
        check(overflow_flag, 32'h1);
        rd_chk(`T8W_ADDR_COUNT, 32'h00, 1'b0);
        svc();
        check(overflow_flag, 32'h0);
        wr(`T8W_ADDR_COMPARE, 32'h05);
        @(posedge clock);
        timer_tick <= 1'b1;
        wr(`T8W_ADDR_COUNT, 32'h05);
        @(posedge clock);
        timer_tick <= 1'b0;
        @(negedge clock);
        check(compare_match_flag, 32'h0);
        rd_chk(`T8W_ADDR_COUNT, 32'h06, 1'b0);
        wr(`T8W_ADDR_COUNT, 32'h04);
        ticks(2);
        check(compare_match_flag, 32'h1);
        wr(`T8W_ADDR_CTRL, 32'h0000_0026);
        wr(`T8W_ADDR_COMPARE, 32'h03);
        wr(`T8W_ADDR_COUNT, 32'h00);
        wr(`T8W_ADDR_FLAGS, 32'h3);
        ticks(4);
        rd_chk(`T8W_ADDR_COUNT, 32'h00, 1'b0);
        check(compare_match_flag, 32'h1);
        check(pin_level, 32'h1);
        svc();
        check(compare_match_flag, 32'h0);
        ticks(4);
        check(pin_level, 32'h0);
        wr(`T8W_ADDR_CTRL, 32'h0000_0006);
        repeat (2) @(negedge clock);
        check({pin_level, waveform_output}, 32'h2);
        wr(`T8W_ADDR_FLAGS, 32'h3);
        wr(`T8W_ADDR_COUNT, 32'h10);
        ticks(240);
        rd_chk(`T8W_ADDR_COUNT, 32'h00, 1'b0);
        check({overflow_flag, compare_match_flag}, 32'h2);
        ticks(4);
        check(compare_match_flag, 32'h1);
        run_pwm(2'h3, 2'h2, 8'h80, 256, 129);
        run_pwm(2'h3, 2'h3, 8'h80, 256, 127);
        run_pwm(2'h3, 2'h2, 8'h00, 256, 1);
        run_pwm(2'h3, 2'h2, 8'hFF, 256, 256);
        run_pwm(2'h3, 2'h3, 8'hFF, 256, 0);
        run_pwm(2'h3, 2'h1, 8'h80, 256, 256);
        run_pwm(2'h1, 2'h2, 8'h40, 510, 128);
        run_pwm(2'h1, 2'h3, 8'h40, 510, 382);
        run_pwm(2'h1, 2'h2, 8'h00, 510, 0);
        run_pwm(2'h1, 2'h2, 8'hFF, 510, 510);
        run_pwm(2'h1, 2'h3, 8'h00, 510, 510);
        run_pwm(2'h1, 2'h1, 8'h40, 510, 510);
        finish_test();
    end

    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        finish_test();
    end
endmodule : tb
